// file: rtl/spc_parity_chk.sv
// Registered parity checker for a group of stored words.
// Assumes bit 31 of each word carries even parity over bits 30..0.
`timescale 1ns/1ps
module spc_parity_chk
  import spc_pkg::*;
#(
  parameter int N = 5
)
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [N-1:0][31:0] words, // Stored words
  output logic [N-1:0] badQ // Mismatch per word
);

  // Compare stored parity with recomputed parity every cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      badQ <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        badQ[i] <= words[i][PAR_BIT] ^ parityOf(words[i]);
      end
    end
  end

endmodule

// file: rtl/spc_pkg.sv
// Constants, types and helpers for the speed profile register bank.
// Assumes a 32-bit Avalon-MM slave with word indices scaled by four.
package spc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FAULT_ONE = 8'h90;
  localparam logic [7:0] IDX_FAULT_TWO = 8'h92;
  localparam logic [7:0] IDX_PROF_FOUR = 8'h9A;
  localparam logic [7:0] IDX_PROF_FIVE = 8'h9C;
  localparam logic [7:0] IDX_PROF_SIX = 8'h9E;
  localparam logic [7:0] IDX_CONTROL = 8'hA0;
  localparam logic [7:0] IDX_STATUS = 8'hA2;

  // Storage slots
  localparam int NUM_WORDS = 5;
  localparam logic [2:0] SLOT_FAULT_ONE = 3'h0;
  localparam logic [2:0] SLOT_FAULT_TWO = 3'h1;
  localparam logic [2:0] SLOT_PROF_FOUR = 3'h2;
  localparam logic [2:0] SLOT_PROF_FIVE = 3'h3;
  localparam logic [2:0] SLOT_PROF_SIX = 3'h4;
  localparam logic [2:0] SLOT_CONTROL = 3'h5;
  localparam logic [2:0] SLOT_STATUS = 3'h6;

  // Field positions (low bit of each field)
  localparam int PAR_BIT = 31;
  localparam int OFF_LO = 23;
  localparam int CLAMP_LO = 15;
  localparam int PT_A_LO = 7;
  localparam int PT_B_HI_LO = 0;
  localparam int PT_B_LSB = 30;
  localparam int PT_C_LO = 22;
  localparam int PT_D_LO = 14;
  localparam int PT_E_LO = 6;
  localparam int CTL_AUTO_BIT = 2;

  // Writable bit masks, reserved bits read zero
  localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_PROF_FIVE = 32'hFFFF_FFC0;
  localparam logic [31:0] MASK_PROF_SIX = 32'hFFFF_8000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE = 2'h3;

  typedef enum logic [1:0] {
    SHAPE_SPEED_REF = 2'h0,
    SHAPE_LINEAR = 2'h1,
    SHAPE_STAIRCASE = 2'h2,
    SHAPE_FWD_REV = 2'h3
  } spc_shape_t;

  // Decoded speed settings and shape; each 8-bit field a fraction over 255 of full scale
  typedef struct packed {
    spc_shape_t shape;
    logic [7:0] turnOffThresholdOne;
    logic [7:0] clampLevelOne;
    logic [7:0] pointA;
    logic [7:0] pointB;
    logic [7:0] pointC;
    logic [7:0] pointD;
    logic [7:0] pointE;
    logic [7:0] turnOffThresholdTwo;
    logic [7:0] clampLevelTwo;
  } spc_speed_t;

  // Even parity over the 31 data bits
  function automatic logic parityOf(input logic [31:0] w);
    parityOf = ^w[30:0];
  endfunction

endpackage

// file: rtl/spc_speed_profile_regs.sv
// Speed profile and fault configuration register bank.
// Assumes an Avalon-MM master on clk; all outputs are registered.
//
// Contract
// - Turn-off threshold one is bits 30..23 of profile word four.
// - Clamp level one is bits 22..15 of profile word four.
// - Speed point A is bits 14..7 of profile word four.
// - Point B joins word four bits 6..0 with word five bit 30.
// - Points C, D, E are word five bits 29..22, 21..14, 13..6.
// - Turn-off threshold two is bits 30..23 of profile word six.
// - Clamp level two is word six bits 22..15; bits 14..0 reserved.
// - Fault words sit at 90h and 92h and reset to zero.
// - Two-bit shape selects reference, linear, staircase or forward-reverse.
`timescale 1ns/1ps
module spc_speed_profile_regs
  import spc_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic srst, // Sync reset, high
  input wire logic [9:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [1:0] avs_response, // Read/write status
  output spc_speed_t speedCfg, // Decoded speeds
  output logic [31:0] faultSetupOne, // Fault word one
  output logic [31:0] faultSetupTwo, // Fault word two
  output logic [NUM_WORDS-1:0] parityErr // Sticky parity flags
);

  logic [NUM_WORDS-1:0][31:0] wordQ;
  logic [1:0] shapeQ;
  logic autoParQ;
  logic [NUM_WORDS-1:0] errQ;
  logic [NUM_WORDS-1:0] badQ;
  logic waitQ;
  logic [31:0] rdataQ;
  logic [1:0] respQ;
  spc_speed_t cfgQ;
  logic [31:0] faultOneQ;
  logic [31:0] faultTwoQ;
  logic [NUM_WORDS-1:0] errOutQ;

  logic req;
  logic hit;
  logic [2:0] slot;
  logic accept;
  logic commit;
  logic [31:0] rdMux;
  logic [31:0] wrMerged;
  logic [31:0] wrWord;
  logic [NUM_WORDS-1:0] errClr;
  logic wrStb;
  logic wordSlot;

  // Map a byte address to a storage slot
  function automatic logic [3:0] decode(input logic [9:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    // Misaligned addresses never hit a register
    if (a[1:0] != 2'h0)
      decode = 4'h0;
    // fault word offsets
    else if (idx == IDX_FAULT_ONE)
      decode = {1'b1, SLOT_FAULT_ONE};
    else if (idx == IDX_FAULT_TWO)
      decode = {1'b1, SLOT_FAULT_TWO};
    else if (idx == IDX_PROF_FOUR)
      decode = {1'b1, SLOT_PROF_FOUR};
    else if (idx == IDX_PROF_FIVE)
      decode = {1'b1, SLOT_PROF_FIVE};
    else if (idx == IDX_PROF_SIX)
      decode = {1'b1, SLOT_PROF_SIX};
    else if (idx == IDX_CONTROL)
      decode = {1'b1, SLOT_CONTROL};
    else if (idx == IDX_STATUS)
      decode = {1'b1, SLOT_STATUS};
    else
      decode = 4'h0;
  endfunction

  // Writable bits of each stored word
  function automatic logic [31:0] slotMask(input logic [2:0] s);
    case (s)
      // word five low bits reserved
      SLOT_PROF_FIVE: slotMask = MASK_PROF_FIVE;
      // word six low bits reserved
      SLOT_PROF_SIX: slotMask = MASK_PROF_SIX;
      default: slotMask = MASK_FULL;
    endcase
  endfunction

  // Merge write data into the old word by byte lane
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    end
    mergeBytes = r;
  endfunction

  // Pick an 8-bit field out of a word
  function automatic logic [7:0] field8(input logic [31:0] w, input int lo);
    field8 = w[lo +: 8];
  endfunction

  assign req = avs_read | avs_write;
  assign {hit, slot} = decode(avs_address);
  // First cycle of a request: answer is prepared
  assign accept = req & waitQ;
  // Second cycle: the master sees waitrequest low
  assign commit = req & ~waitQ;
  // Writes land only on that edge, so a held request is never stored twice
  assign wrStb = commit & avs_write & hit;
  // Control and status live outside the stored word array
  assign wordSlot = slot < SLOT_CONTROL;

  // Write data merged and masked for the addressed slot
  always_comb
  begin
    wrMerged = RST_WORD;
    wrWord = RST_WORD;
    // Out-of-range slots must not index the word array
    if (wordSlot)
    begin
      wrMerged = mergeBytes(wordQ[slot], avs_writedata, avs_byteenable);
    end
    wrWord = wrMerged & slotMask(slot);
    // parity computed on store
    if (autoParQ)
    begin
      wrWord[PAR_BIT] = parityOf(wrWord);
    end
  end

  // One wait state, then a single-cycle answer
  // Registered answer costs a cycle but keeps the decode off the bus path
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      waitQ <= 1'b1;
    end
    else
    begin
      waitQ <= ~accept;
    end
  end

  // Read data mux
  // Unmapped or misaligned reads return zero
  always_comb
  begin
    rdMux = RST_WORD;
    if (hit)
    begin
      case (slot)
        SLOT_FAULT_ONE: rdMux = wordQ[SLOT_FAULT_ONE];
        SLOT_FAULT_TWO: rdMux = wordQ[SLOT_FAULT_TWO];
        SLOT_PROF_FOUR: rdMux = wordQ[SLOT_PROF_FOUR];
        SLOT_PROF_FIVE: rdMux = wordQ[SLOT_PROF_FIVE];
        SLOT_PROF_SIX: rdMux = wordQ[SLOT_PROF_SIX];
        SLOT_CONTROL: rdMux = {29'h0, autoParQ, shapeQ};
        SLOT_STATUS: rdMux = {27'h0, errQ};
        default: rdMux = RST_WORD;
      endcase
    end
  end

  // Read data and response captured on the first cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdataQ <= RST_WORD;
      respQ <= RESP_OKAY;
    end
    else if (accept)
    begin
      rdataQ <= avs_read ? rdMux : RST_WORD;
      respQ <= hit ? RESP_OKAY : RESP_DECODE;
    end
  end

  // Stored profile and fault words
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // zero after reset
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        wordQ[i] <= RST_WORD;
      end
    end
    // unmapped writes dropped
    else if (wrStb && wordSlot)
    begin
      wordQ[slot] <= wrWord;
    end
  end

  // Control word: profile shape and parity mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shapeQ <= SHAPE_SPEED_REF;
      autoParQ <= 1'b1;
    end
    else if (wrStb && slot == SLOT_CONTROL)
    begin
      // Only byte lane 0 carries control bits
      if (avs_byteenable[0])
      begin
        // shape selector stored
        shapeQ <= avs_writedata[1:0];
        autoParQ <= avs_writedata[CTL_AUTO_BIT];
      end
    end
  end

  // Write-one-to-clear mask for the status word
  always_comb
  begin
    errClr = '0;
    // A clear without lane 0 is ignored
    if (wrStb && slot == SLOT_STATUS && avs_byteenable[0])
    begin
      errClr = avs_writedata[NUM_WORDS-1:0];
    end
  end

  // parity of stored words checked every cycle
  spc_parity_chk #(
    .N(NUM_WORDS)
  ) u_par (
    .clk(clk),
    .srst(srst),
    .words(wordQ),
    .badQ(badQ)
  );

  // Sticky parity errors; a new error beats a clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      errQ <= '0;
    end
    else
    begin
      // set wins over clear
      errQ <= (errQ & ~errClr) | badQ;
    end
  end

  // Decoded speed fields, one cycle behind the words
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfgQ <= '0;
    end
    else
    begin
      // shape drives profile mode
      cfgQ.shape <= spc_shape_t'(shapeQ);
      // first turn-off threshold
      cfgQ.turnOffThresholdOne <= field8(wordQ[SLOT_PROF_FOUR], OFF_LO);
      // first clamp level
      cfgQ.clampLevelOne <= field8(wordQ[SLOT_PROF_FOUR], CLAMP_LO);
      // speed point A
      cfgQ.pointA <= field8(wordQ[SLOT_PROF_FOUR], PT_A_LO);
      // point B reassembled
      cfgQ.pointB <= {wordQ[SLOT_PROF_FOUR][PT_B_HI_LO +: 7],
                      wordQ[SLOT_PROF_FIVE][PT_B_LSB]};
      // points C, D, E
      cfgQ.pointC <= field8(wordQ[SLOT_PROF_FIVE], PT_C_LO);
      cfgQ.pointD <= field8(wordQ[SLOT_PROF_FIVE], PT_D_LO);
      cfgQ.pointE <= field8(wordQ[SLOT_PROF_FIVE], PT_E_LO);
      // second turn-off threshold
      cfgQ.turnOffThresholdTwo <= field8(wordQ[SLOT_PROF_SIX], OFF_LO);
      // second clamp level
      cfgQ.clampLevelTwo <= field8(wordQ[SLOT_PROF_SIX], CLAMP_LO);
    end
  end

  // Fault words and error flags towards the core
  // Fault fields pass through untouched; their meaning lives in the core
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      faultOneQ <= RST_WORD;
      faultTwoQ <= RST_WORD;
      errOutQ <= '0;
    end
    else
    begin
      faultOneQ <= wordQ[SLOT_FAULT_ONE];
      faultTwoQ <= wordQ[SLOT_FAULT_TWO];
      errOutQ <= errQ;
    end
  end

  assign avs_readdata = rdataQ;
  assign avs_waitrequest = waitQ;
  assign avs_response = respQ;
  assign speedCfg = cfgQ;
  assign faultSetupOne = faultOneQ;
  assign faultSetupTwo = faultTwoQ;
  assign parityErr = errOutQ;

endmodule

// file: testbench/spc_speed_profile_regs_bench.sv
// Self-checking bench for the speed profile register bank.
// Assumes one wait cycle per access; decoded outputs lag the store.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e); end end
module spc_speed_profile_regs_bench
  import spc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] resp;
  logic [31:0] f1;
  logic [31:0] f2;
  logic [4:0] perr;
  spc_speed_t cfg;
  logic [31:0] got;
  logic [1:0] gotResp;
  logic [31:0] bad;
  logic [31:0] mdl [logic [9:0]];
  logic [9:0] regs [5] = '{10'h240, 10'h248, 10'h268, 10'h270, 10'h278};
  int errors = 0;
  int checks_done = 0;

  spc_speed_profile_regs i_spc_speed_profile_regs (.clk(clk), .srst(srst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .avs_response(resp), .speedCfg(cfg), .faultSetupOne(f1),
    .faultSetupTwo(f2), .parityErr(perr));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hold request until waitrequest low; extra edge avoids double drive
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    got = rdata;
    gotResp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Model keeps masked word with even parity in bit 31
  task automatic put(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] m;
    m = d & (a == 10'h270 ? MASK_PROF_FIVE : a == 10'h278 ? MASK_PROF_SIX : MASK_FULL);
    m[31] = ^m[30:0];
    acc(1'b1, a, d);
    mdl[a] = m;
  endtask

  task automatic get(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(got, e)
    `CHK(gotResp, r)
  endtask

  // Decoded fields against model words
  task automatic dec();
    logic [31:0] p4;
    logic [31:0] p5;
    logic [31:0] p6;
    p4 = mdl[10'h268];
    p5 = mdl[10'h270];
    p6 = mdl[10'h278];
    repeat (2) @(posedge clk);
    `CHK(cfg.turnOffThresholdOne, p4[30:23])
    `CHK(cfg.clampLevelOne, p4[22:15])
    `CHK(cfg.pointA, p4[14:7])
    `CHK(cfg.pointB, {p4[6:0], p5[30]})
    `CHK({cfg.pointC, cfg.pointD, cfg.pointE}, p5[29:6])
    `CHK(cfg.turnOffThresholdTwo, p6[30:23])
    `CHK(cfg.clampLevelTwo, p6[22:15])
    `CHK({f1, f2}, {mdl[10'h240], mdl[10'h248]})
    `CHK(perr, 5'h00)
  endtask

  initial
  begin
    void'($urandom(19110));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (regs[i])
    begin
      mdl[regs[i]] = 32'h0000_0000;
      get(regs[i], 32'h0000_0000, RESP_OKAY);
    end
    $display("Test reset values done");
    repeat (4)
    begin
      foreach (regs[i])
        put(regs[i], $urandom);
      foreach (regs[i])
        get(regs[i], mdl[regs[i]], RESP_OKAY);
      dec();
    end
    $display("Test random words done");
    be <= 4'h3;
    bad = $urandom;
    acc(1'b1, 10'h240, bad);
    be <= 4'hF;
    bad = {mdl[10'h240][31:16], bad[15:0]};
    bad[31] = ^bad[30:0];
    mdl[10'h240] = bad;
    get(10'h240, bad, RESP_OKAY);
    $display("Test byte lanes done");
    // reserved offsets untouched
    // Stray offset outside the fault group, then a misaligned one
    acc(1'b1, 10'h3FC, $urandom);
    `CHK(gotResp, RESP_DECODE)
    get(10'h3FC, 32'h0000_0000, RESP_DECODE);
    get(10'h242, 32'h0000_0000, RESP_DECODE);
    dec();
    $display("Test unmapped done");
    for (int s = 0; s < 4; s++)
    begin
      acc(1'b1, 10'h280, 32'h0000_0004 | s);
      repeat (2) @(posedge clk);
      `CHK(cfg.shape, spc_shape_t'(s))
    end
    $display("Test shapes done");
    // Auto parity off, so a wrong bit 31 is kept and flagged
    acc(1'b1, 10'h280, 32'h0000_0000);
    bad = $urandom;
    bad[31] = ~^bad[30:0];
    acc(1'b1, 10'h268, bad);
    get(10'h268, bad, RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(perr, 5'h04)
    acc(1'b1, 10'h288, 32'h0000_0004);
    get(10'h288, 32'h0000_0004, RESP_OKAY);
    $display("Test parity done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (regs[i])
    begin
      mdl[regs[i]] = 32'h0000_0000;
      get(regs[i], 32'h0000_0000, RESP_OKAY);
    end
    get(10'h280, 32'h0000_0004, RESP_OKAY);
    get(10'h288, 32'h0000_0000, RESP_OKAY);
    dec();
    `CHK(cfg.shape, SHAPE_SPEED_REF)
    $display("Test mid-run reset done");
    finish_test();
  end

  // Run needs about 240 cycles; the 6000-cycle limit means a hang
  initial
  begin
    #60000;
    errors++;
    finish_test();
  end
endmodule

bind spc_speed_profile_regs spc_speed_profile_regs_checker i_chk (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .avs_response, .speedCfg, .faultSetupTwo);

// file: testbench/spc_speed_profile_regs_checker.sv
// Port checker for the speed profile register bank.
// Assumes it is bound to the bank top; one clock, sync reset.
`timescale 1ns/1ps
module spc_speed_profile_regs_checker
  import spc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic [9:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic avs_waitrequest, // Stall
  input wire logic [1:0] avs_response, // Status
  input wire spc_speed_t speedCfg, // Speeds
  input wire logic [31:0] faultSetupTwo // Fault two
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Full write taken; store next edge, decode one later
  sequence wrDone(a);
    avs_write && !avs_waitrequest && avs_byteenable == 4'hF && avs_address == a;
  endsequence

  chk_off_one: assert property (wrDone(10'h268) |-> ##2
    speedCfg.turnOffThresholdOne == $past(avs_writedata[30:23], 2)) else $error("threshold one wrong");
  chk_point_b: assert property (wrDone(10'h270) |-> ##2
    speedCfg.pointB[0] == $past(avs_writedata[30], 2)) else $error("point B low bit wrong");
  chk_clamp_two: assert property (wrDone(10'h278) |-> ##2
    speedCfg.clampLevelTwo == $past(avs_writedata[22:15], 2)) else $error("clamp two wrong");
  chk_fault_two: assert property (wrDone(10'h248) |-> ##2
    faultSetupTwo[30:0] == $past(avs_writedata[30:0], 2)) else $error("fault two wrong");
  chk_bad_addr: assert property ((avs_read || avs_write) && !avs_waitrequest
    && avs_address[1:0] != 2'h0 |-> avs_response == RESP_DECODE) else $error("no decode error");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_reset_zero: assert property ($fell(srst) |->
    faultSetupTwo == 32'h0000_0000 && avs_waitrequest) else $error("reset state wrong");
endmodule
